// File: pkg/serial_cfg_pkg.sv
// constants, types and decode helpers shared by the serial register bank
package serial_cfg_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [12:0] ADDR_PORT_CFG = 13'h000;
    localparam logic [12:0] ADDR_CHIP_ID = 13'h001;
    localparam logic [12:0] ADDR_GRADE = 13'h002;
    localparam logic [12:0] ADDR_INDEX = 13'h005;
    localparam logic [12:0] ADDR_POWER = 13'h008;
    localparam logic [12:0] ADDR_CLOCK = 13'h009;
    localparam logic [12:0] ADDR_XFER = 13'h0ff;
    localparam logic [12:0] ADDR_TEST = 13'h00d;
    localparam logic [12:0] ADDR_OFFSET = 13'h010;
    localparam logic [12:0] ADDR_OUT_MODE = 13'h014;
    localparam logic [12:0] ADDR_OUT_PHASE = 13'h016;

    // ------------------------------------------------------------
    // reset values and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] PORT_CFG_RESET = 8'h18;
    localparam logic [7:0] INDEX_RESET = 8'h33;
    localparam logic [7:0] INDEX_MASK = 8'h33;
    localparam logic [7:0] LOCAL_RESET = 8'h00;
    localparam logic [1:0] POWER_RESET = 2'h0;
    localparam logic DCS_RESET = 1'b0;
    localparam logic [1:0] PM_FULL_DOWN = 2'h1;
    localparam logic [1:0] PM_STANDBY = 2'h2;
    localparam int SOFT_RST_HI = 5;
    localparam int SOFT_RST_LO = 2;
    localparam int IDX_A = 0;
    localparam int IDX_B = 1;
    localparam int IDX_FCO = 4;
    localparam int IDX_DCO = 5;
    localparam logic [1:0] SLOT_OUT_MODE = 2'h2;

    // ------------------------------------------------------------
    // frame and timing constants
    // ------------------------------------------------------------
    localparam logic [1:0] STRAP_WAIT = 2'h3;
    localparam logic [3:0] INSTR_LAST = 4'hf;
    localparam logic [3:0] BYTE_LAST = 4'h7;
    localparam logic [1:0] LEN_STREAM = 2'h3;

    typedef enum logic [2:0] {
        ST_INSTR = 3'b001,
        ST_WDATA = 3'b010,
        ST_RDATA = 3'b100
    } phase_type;

    // {valid, slot} of a per-channel register
    function automatic logic [2:0] local_slot(input logic [12:0] a);
        case (a)
            ADDR_TEST: return 3'b100;
            ADDR_OFFSET: return 3'b101;
            ADDR_OUT_MODE: return 3'b110;
            ADDR_OUT_PHASE: return 3'b111;
            default: return 3'b000;
        endcase
    endfunction

endpackage

// File: rtl/local_copy_mem.sv
// per-channel copies of the local registers
`timescale 1ns/100ps
module local_copy_mem import serial_cfg_pkg::*; (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clr,
    input wire logic we,
    input wire logic [3:0] mask,
    input wire logic [1:0] wslot,
    input wire logic [7:0] wdata,
    input wire logic [1:0] rchan,
    input wire logic [1:0] rslot,
    output logic [7:0] rdata
);

    typedef struct packed {
        logic [3:0][3:0][7:0] cells;
        logic [7:0] rdata_ff;
    } mem_type;

    mem_type s;
    mem_type n;

    // ------------------------------------------------------------
    // write by channel mask, registered read
    // ------------------------------------------------------------
    always_comb begin
        n = s;
        for (int ch = 0; ch < 4; ch++) begin
            if (clr) begin
                for (int k = 0; k < 4; k++) begin
                    n.cells[ch][k] = LOCAL_RESET;
                end
            end else if (we && mask[ch]) begin
                n.cells[ch][wslot] = wdata;
            end
        end
        n.rdata_ff = s.cells[rchan][rslot];
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign rdata = s.rdata_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_bcast_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
        we && !clr && mask == 4'hf |=> s.cells[0][$past(wslot)] == $past(wdata)
        && s.cells[1][$past(wslot)] == $past(wdata) && s.cells[2][$past(wslot)] == $past(wdata)
        && s.cells[3][$past(wslot)] == $past(wdata))
        else $error("broadcast write missed a channel copy");
    a_copy_apart: assert property (@(posedge clk_sys) disable iff (sys_rst)
        we && !clr && !mask[1] |=> $stable(s.cells[1]))
        else $error("unselected channel copy changed");

endmodule

// File: rtl/serial_config_register_bank.sv
// serial configuration port and register bank of a dual-channel converter
`timescale 1ns/100ps
module serial_config_register_bank import serial_cfg_pkg::*; #(
    parameter logic [7:0] CHIP_ID_VALUE = 8'h5a, // arbitrary value
    parameter logic [7:0] GRADE_VALUE = 8'h00 // arbitrary value
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic serial_clock_format_strap,
    input wire logic port_select_n,
    input wire logic serial_io_powerdown_strap_i,
    output logic serial_io_powerdown_strap_o,
    output logic serial_io_powerdown_strap_oe_n,
    output logic output_twos_complement,
    output logic power_down,
    output logic standby,
    output logic duty_cycle_stabilizer_on,
    output logic override_transfer
);

    typedef struct packed {
        logic [2:0] sclk_s;
        logic [1:0] csn_s;
        logic [1:0] sdi_s;
        phase_type phase;
        logic [15:0] shift;
        logic [3:0] bit_cnt;
        logic [1:0] byte_cnt;
        logic [1:0] len;
        logic [12:0] addr;
        logic [7:0] rd_sh;
        logic [7:0] dev_index;
        logic [1:0] power_mode;
        logic dcs_on;
        logic fmt_local;
        logic soft_rst;
        logic [1:0] strap_cnt;
        logic strap_done;
        logic spi_en;
        logic strap_fmt;
        logic strap_pdwn;
        logic sdio_out;
        logic sdio_oe_n;
        logic twos_out;
        logic pdwn_out;
        logic standby_out;
        logic xfer_out;
    } bank_type;

    bank_type s;
    bank_type n;
    logic csn;
    logic rise;
    logic fall;
    logic active;
    logic wr_en;
    logic [7:0] wr_data;
    logic [7:0] rd_mux;
    logic [2:0] wslot;
    logic [2:0] rslot;
    logic [3:0] mem_mask;
    logic [1:0] mem_rchan;
    logic mem_we;
    logic mem_clr;
    logic [7:0] mem_rdata;

    // ------------------------------------------------------------
    // per-channel local registers
    // ------------------------------------------------------------
    local_copy_mem u_copies (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .clr(mem_clr),
        .we(mem_we),
        .mask(mem_mask),
        .wslot(wslot[1:0]),
        .wdata(wr_data),
        .rchan(mem_rchan),
        .rslot(rslot[1:0]),
        .rdata(mem_rdata)
    );

    // ------------------------------------------------------------
    // read data selection
    // ------------------------------------------------------------
    always_comb begin
        rslot = local_slot(s.addr);
        if (s.dev_index[IDX_A]) begin
            mem_rchan = 2'h0;
        end else if (s.dev_index[IDX_B]) begin
            mem_rchan = 2'h1;
        end else if (s.dev_index[IDX_DCO]) begin
            mem_rchan = 2'h2;
        end else begin
            mem_rchan = 2'h3;
        end
        case (s.addr)
            ADDR_PORT_CFG: rd_mux = PORT_CFG_RESET;
            ADDR_CHIP_ID: rd_mux = CHIP_ID_VALUE;
            ADDR_GRADE: rd_mux = GRADE_VALUE;
            ADDR_INDEX: rd_mux = s.dev_index;
            ADDR_POWER: rd_mux = {6'h00, s.power_mode};
            ADDR_CLOCK: rd_mux = {7'h00, s.dcs_on};
            default: rd_mux = rslot[2] ? mem_rdata : 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // frame engine and register writes
    // ------------------------------------------------------------
    always_comb begin
        n = s;
        n.sclk_s = {s.sclk_s[1:0], serial_clock_format_strap};
        n.csn_s = {s.csn_s[0], port_select_n};
        n.sdi_s = {s.sdi_s[0], serial_io_powerdown_strap_i};
        n.xfer_out = 1'b0;
        csn = s.csn_s[1];
        rise = s.sclk_s[1] && !s.sclk_s[2];
        fall = !s.sclk_s[1] && s.sclk_s[2];
        active = s.spi_en && s.strap_done && !csn;
        wr_en = 1'b0;
        wr_data = 8'h00;
        mem_clr = 1'b0;
        if (!s.strap_done) begin
            n.strap_cnt = s.strap_cnt + 2'h1;
            if (s.strap_cnt == STRAP_WAIT) begin
                n.strap_done = 1'b1;
                n.spi_en = !csn;
                n.strap_fmt = s.sclk_s[1];
                n.strap_pdwn = s.sdi_s[1];
            end
        end
        if (csn) begin
            n.sdio_oe_n = 1'b1;
            if (s.len == LEN_STREAM && s.phase != ST_INSTR) begin
                n.phase = ST_INSTR;
                n.bit_cnt = 4'h0;
            end
        end
        if (active && rise) begin
            n.shift = {s.shift[14:0], s.sdi_s[1]};
            n.bit_cnt = s.bit_cnt + 4'h1;
            case (s.phase)
                ST_INSTR: begin
                    if (s.bit_cnt == INSTR_LAST) begin
                        n.addr = n.shift[12:0];
                        n.len = n.shift[14:13];
                        n.byte_cnt = 2'h0;
                        n.bit_cnt = 4'h0;
                        n.phase = n.shift[15] ? ST_RDATA : ST_WDATA;
                    end
                end
                ST_WDATA, ST_RDATA: begin
                    if (s.bit_cnt == BYTE_LAST) begin
                        wr_en = (s.phase == ST_WDATA);
                        wr_data = n.shift[7:0];
                        n.addr = s.addr - 13'h1;
                        n.bit_cnt = 4'h0;
                        n.byte_cnt = s.byte_cnt + 2'h1;
                        if (s.len != LEN_STREAM && s.byte_cnt == s.len) begin
                            n.phase = ST_INSTR;
                            n.sdio_oe_n = 1'b1;
                        end
                    end
                end
                default: n.phase = ST_INSTR;
            endcase
        end
        if (active && fall && s.phase == ST_RDATA) begin
            n.sdio_oe_n = 1'b0;
            if (s.bit_cnt == 4'h0) begin
                n.sdio_out = rd_mux[7];
                n.rd_sh = {rd_mux[6:0], 1'b0};
            end else begin
                n.sdio_out = s.rd_sh[7];
                n.rd_sh = {s.rd_sh[6:0], 1'b0};
            end
        end
        wslot = local_slot(s.addr);
        mem_mask = {s.dev_index[IDX_FCO], s.dev_index[IDX_DCO],
                    s.dev_index[IDX_B], s.dev_index[IDX_A]};
        mem_we = wr_en && wslot[2];
        if (wr_en) begin
            case (s.addr)
                ADDR_PORT_CFG: n.soft_rst = wr_data[SOFT_RST_HI] || wr_data[SOFT_RST_LO];
                ADDR_INDEX: n.dev_index = wr_data & INDEX_MASK;
                ADDR_POWER: n.power_mode = wr_data[1:0];
                ADDR_CLOCK: n.dcs_on = wr_data[0];
                ADDR_XFER: n.xfer_out = wr_data[0];
                default: begin
                    // per-channel addresses are stored only in the copies and other unlisted addresses are ignored; an output-mode write with channel A selected also sets the format
                    if (wslot[2] && wslot[1:0] == SLOT_OUT_MODE && s.dev_index[IDX_A]) begin
                        n.fmt_local = wr_data[0];
                    end
                end
            endcase
        end
        if (s.soft_rst) begin
            n.soft_rst = 1'b0;
            n.dev_index = INDEX_RESET;
            n.power_mode = POWER_RESET;
            n.dcs_on = DCS_RESET;
            n.fmt_local = 1'b0;
            mem_clr = 1'b1;
        end
        n.twos_out = s.spi_en ? s.fmt_local : s.strap_fmt;
        n.pdwn_out = s.spi_en ? (s.power_mode == PM_FULL_DOWN) : s.strap_pdwn;
        n.standby_out = s.spi_en && s.power_mode == PM_STANDBY;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s <= '0;
            s.phase <= ST_INSTR;
            s.dev_index <= INDEX_RESET;
            s.sdio_oe_n <= 1'b1;
        end else begin
            s <= n;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign serial_io_powerdown_strap_o = s.sdio_out;
    assign serial_io_powerdown_strap_oe_n = s.sdio_oe_n;
    assign output_twos_complement = s.twos_out;
    assign power_down = s.pdwn_out;
    assign standby = s.standby_out;
    assign duty_cycle_stabilizer_on = s.dcs_on;
    assign override_transfer = s.xfer_out;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_index_default: assert property ($past(sys_rst) |-> s.dev_index == INDEX_RESET)
        else $error("channel index not at default after reset");
    a_drive_readback: assert property (!s.sdio_oe_n |-> s.phase == ST_RDATA || csn)
        else $error("data pin driven outside readback");
    a_strap_quiet: assert property (!s.spi_en |-> s.sdio_oe_n && !s.soft_rst)
        else $error("port active while strapped");
    a_strap_hold: assert property (s.strap_done |=> $stable(s.strap_fmt) && $stable(s.spi_en))
        else $error("strap setting changed after capture");
    a_soft_restore: assert property (s.soft_rst |=> s.dev_index == INDEX_RESET
        && s.power_mode == POWER_RESET && !s.soft_rst)
        else $error("soft reset did not restore defaults");
    a_soft_source: assert property ($rose(s.soft_rst) |-> $past(wr_en) && s.spi_en)
        else $error("soft reset without a port write");
    a_global_write: assert property (wr_en && s.addr == ADDR_POWER
        |=> s.power_mode == $past(wr_data[1:0]))
        else $error("global write lost");
    a_index_write: assert property (wr_en && s.addr == ADDR_INDEX && !s.soft_rst
        |=> s.dev_index == ($past(wr_data) & INDEX_MASK))
        else $error("index write not stored");
    a_instr_length: assert property (active && rise && s.phase == ST_INSTR
        && s.bit_cnt == INSTR_LAST |=> s.phase != ST_INSTR && s.bit_cnt == 4'h0)
        else $error("instruction phase not sixteen bits");
    a_read_chan_a: assert property (s.dev_index[IDX_A] && s.dev_index[IDX_B]
        |-> mem_rchan == 2'h0)
        else $error("broadcast read not from channel a");
    a_strap_drive: assert property (s.strap_done && !s.spi_en
        |=> s.twos_out == $past(s.strap_fmt) && s.pdwn_out == $past(s.strap_pdwn))
        else $error("strap levels not on the outputs");
    a_stall_hold: assert property (csn && s.len != LEN_STREAM
        |=> $stable(s.bit_cnt) && $stable(s.phase) && $stable(s.addr))
        else $error("frame moved while select high");
    a_transfer_pulse: assert property (wr_en && s.addr == ADDR_XFER && wr_data[0]
        |=> s.xfer_out ##1 !s.xfer_out)
        else $error("transfer pulse not one cycle");
    a_read_msb: assert property (active && fall && s.phase == ST_RDATA
        && s.bit_cnt == 4'h0 |=> !s.sdio_oe_n && s.sdio_out == $past(rd_mux[7]))
        else $error("readback did not start at bit seven");

    c_read_frame: cover property (s.phase == ST_INSTR ##1 s.phase == ST_RDATA);
    c_index_write: cover property (wr_en && s.addr == ADDR_INDEX);
    c_soft_reset: cover property (s.soft_rst);
    c_strap_mode: cover property (s.strap_done && !s.spi_en && s.pdwn_out);
    c_stream_frame: cover property (s.len == LEN_STREAM && wr_en);

endmodule

// File: verification/serial_config_register_bank_test.sv
// self-checking bench for the serial register bank
`timescale 1ns/100ps
module serial_config_register_bank_test import serial_cfg_pkg::*; ();
    localparam logic [7:0] ID_VAL = 8'h3c; // arbitrary value
    localparam logic [7:0] GRADE_VAL = 8'h20; // arbitrary value
    logic clk_sys, sys_rst, sclk, cs_n, line, d_o, oe_n;
    logic fmt, pdn, stby, duty_cycle_stabilizer, ovr;
    logic [15:0] r;
    int n_fail, num_checks, n_ovr;

    serial_config_register_bank #(.CHIP_ID_VALUE(ID_VAL), .GRADE_VALUE(GRADE_VAL))
        i_serial_config_register_bank (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .serial_clock_format_strap(sclk),
        .port_select_n(cs_n),
        .serial_io_powerdown_strap_i(line),
        .serial_io_powerdown_strap_o(d_o),
        .serial_io_powerdown_strap_oe_n(oe_n),
        .output_twos_complement(fmt),
        .power_down(pdn),
        .standby(stby),
        .duty_cycle_stabilizer_on(duty_cycle_stabilizer),
        .override_transfer(ovr)
    );

    serial_host_model i_serial_host_model (
        .clk_sys(clk_sys),
        .dev_d(d_o),
        .dev_oe_n(oe_n),
        .sclk(sclk),
        .cs_n(cs_n),
        .line(line)
    );

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    always @(negedge clk_sys) begin
        if (ovr === 1'b1) begin
            n_ovr++;
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic conclude;
        if (n_fail == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        i_serial_host_model.frame(1'b0, 2'h0, a, {d, 8'h00}, 1'b0, r);
    endtask

    task automatic rd(input logic [12:0] a, input logic [7:0] e);
        i_serial_host_model.frame(1'b1, 2'h0, a, 16'h0000, 1'b0, r);
        chk($sformatf("reg %h", a), e, r[7:0]);
    endtask

    task automatic do_reset(input logic c, input logic d, input logic s);
        @(negedge clk_sys);
        i_serial_host_model.strap(c, d, s);
        sys_rst = 1'b1;
        repeat (6) @(negedge clk_sys);
        sys_rst = 1'b0;
        repeat (12) @(negedge clk_sys);
        i_serial_host_model.strap(1'b0, 1'b0, 1'b1);
    endtask

    initial begin
        repeat (60000) @(posedge clk_sys);
        n_fail++;
        conclude();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        // strap mode: pins set format and power-down, port ignored
        for (int k = 0; k < 2; k++) begin
            do_reset(k[0], !k[0], 1'b1);
            chk("format", {7'h0, k[0]}, {7'h0, fmt});
            chk("power down", {7'h0, !k[0]}, {7'h0, pdn});
            wr(ADDR_POWER, 8'h02);
            wr(ADDR_PORT_CFG, 8'h3c);
            chk("strap hold", {6'h0, k[0], !k[0]}, {6'h0, fmt, pdn});
            chk("standby", 8'h00, {7'h0, stby});
        end
        do_reset(1'b0, 1'b0, 1'b0);
        rd(ADDR_PORT_CFG, 8'h18);
        rd(ADDR_CHIP_ID, ID_VAL);
        rd(ADDR_GRADE, GRADE_VAL);
        rd(ADDR_INDEX, 8'h33);
        rd(ADDR_POWER, 8'h00);
        // per-channel copies
        wr(ADDR_OUT_MODE, 8'h01);
        chk("twos complement", 8'h01, {7'h0, fmt});
        wr(ADDR_INDEX, 8'h01);
        wr(ADDR_OFFSET, 8'h11);
        wr(ADDR_INDEX, 8'h02);
        wr(ADDR_OFFSET, 8'h22);
        rd(ADDR_OFFSET, 8'h22);
        rd(ADDR_OUT_MODE, 8'h01);
        // clock channel copies must not leak into the data channels
        wr(ADDR_INDEX, 8'h20);
        wr(ADDR_TEST, 8'h05);
        wr(ADDR_INDEX, 8'h10);
        wr(ADDR_OFFSET, 8'h44);
        wr(ADDR_INDEX, 8'h01);
        rd(ADDR_TEST, 8'h00);
        rd(ADDR_OFFSET, 8'h11);
        wr(ADDR_INDEX, 8'h02);
        rd(ADDR_TEST, 8'h00);
        wr(ADDR_INDEX, 8'h33);
        rd(ADDR_OFFSET, 8'h11);
        // shared registers ignore the index
        wr(ADDR_INDEX, 8'h01);
        wr(ADDR_CLOCK, 8'h01);
        chk("stabilizer", 8'h01, {7'h0, duty_cycle_stabilizer});
        wr(ADDR_INDEX, 8'h02);
        rd(ADDR_CLOCK, 8'h01);
        // mode 3 is a digital reset and drives neither output
        for (int m = 1; m < 4; m++) begin
            wr(ADDR_POWER, m[7:0]);
            chk("power modes", (m == 3) ? 8'h00 : m[7:0], {6'h0, stby, pdn});
        end
        wr(ADDR_XFER, 8'h01);
        chk("override pulses", 8'h01, n_ovr[7:0]);
        rd(ADDR_XFER, 8'h00);
        // unlisted address is only read, never written
        rd(13'h013, 8'h00);
        // two bytes: 0x09 then 0x08
        i_serial_host_model.frame(1'b0, 2'h1, ADDR_CLOCK, 16'h0000, 1'b0, r);
        chk("two byte write", 8'h00, {6'h0, duty_cycle_stabilizer, stby});
        i_serial_host_model.frame(1'b0, 2'h0, ADDR_CLOCK, 16'h0100, 1'b1, r);
        chk("stalled write", 8'h01, {7'h0, duty_cycle_stabilizer});
        // streaming frame ended by select high, then a two byte readback
        i_serial_host_model.frame(1'b0, 2'h3, ADDR_CLOCK, 16'h0102, 1'b0, r);
        chk("stream write", 8'h03, {6'h0, duty_cycle_stabilizer, stby});
        i_serial_host_model.frame(1'b1, 2'h1, ADDR_CLOCK, 16'h0000, 1'b0, r);
        chk("two byte read first", 8'h01, r[15:8]);
        chk("two byte read second", 8'h02, r[7:0]);
        // soft reset through the port
        wr(ADDR_PORT_CFG, 8'h3c);
        rd(ADDR_PORT_CFG, 8'h18);
        rd(ADDR_INDEX, 8'h33);
        chk("soft reset outputs", 8'h00, {5'h0, duty_cycle_stabilizer, stby, fmt});
        chk("line clash", 8'h00, i_serial_host_model.n_clash[7:0]);
        conclude();
    end
endmodule

// File: verification/serial_host_model.sv
// host model driving the three-wire configuration link
`timescale 1ns/100ps
module serial_host_model (
    input wire logic clk_sys,
    input wire logic dev_d,
    input wire logic dev_oe_n,
    output logic sclk,
    output logic cs_n,
    output logic line
);
    logic d_out;
    logic d_en;
    logic idle_bit;
    int n_clash;

    // ------------------------------------------------------------
    // wire level
    // ------------------------------------------------------------
    // released line shows a changing pattern, never the last bit
    assign line = !dev_oe_n ? dev_d : d_en ? d_out : idle_bit;

    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        d_out = 1'b0;
        d_en = 1'b0;
        idle_bit = 1'b0;
    end

    always @(negedge clk_sys) begin
        idle_bit <= ~idle_bit;
    end

    always @(posedge clk_sys) begin
        if (dev_oe_n === 1'b0 && d_en) begin
            n_clash++;
        end
    end

    // ------------------------------------------------------------
    // host actions
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // static pin levels; select high keeps the port off
    task automatic strap(input logic c, input logic d, input logic s);
        sclk = c;
        d_out = d;
        d_en = 1'b1;
        cs_n = s;
    endtask

    // instruction then one byte for len 0, two bytes for any other len, taken from wd msb first; stall lifts select once
    task automatic frame(input logic rd, input logic [1:0] len, input logic [12:0] addr,
                         input logic [15:0] wd, input logic stall, output logic [15:0] rdat);
        logic [31:0] sh;
        int nb;
        sh = {rd, len, addr, wd};
        // stream (len 3) sends two bytes, then select high ends it
        nb = (len == 2'h0) ? 24 : 32;
        rdat = 16'h0000;
        tick(1);
        cs_n = 1'b0;
        for (int i = 0; i < nb; i++) begin
            if (stall && i == 16) begin
                cs_n = 1'b1;
                tick(16);
                cs_n = 1'b0;
            end
            d_en = !(rd && i >= 16);
            d_out = sh[31 - i];
            tick(4);
            sclk = 1'b1;
            if (i >= 16) begin
                rdat = {rdat[14:0], line};
            end
            tick(4);
            sclk = 1'b0;
        end
        d_en = 1'b0;
        tick(4);
        cs_n = 1'b1;
        tick(8);
    endtask
endmodule
